//--- logic/acc_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * comparator control block. Assumes inclusion by bare name; definitions only.
 */
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// Register byte offsets
`define ACC_CTRL_OFS         8'h00
`define ACC_INPUT_SEL_OFS    8'h02
`define ACC_IRQ_ENABLE_OFS   8'h06
`define ACC_STATE_FLAG_OFS   8'h07

// Control register fields
`define ACC_CTRL_ENABLE_BIT  0
`define ACC_CTRL_EDGE_LSB    4
`define ACC_CTRL_EDGE_MSB    5
`define ACC_CTRL_MASK        8'h31

// Input select fields
`define ACC_SEL_INVERT_BIT   7
`define ACC_SEL_POS_LSB      3
`define ACC_SEL_POS_MSB      4
`define ACC_SEL_NEG_LSB      0
`define ACC_SEL_NEG_MSB      1
`define ACC_SEL_MASK         8'h9B

// Interrupt enable and status fields
`define ACC_IRQ_BIT          0
`define ACC_STATE_BIT        4

// Reset values
`define ACC_CTRL_RST         8'h00
`define ACC_SEL_RST          8'h00
`define ACC_IRQ_EN_RST       8'h00
`define ACC_STATUS_RST       8'h00

// Synchroniser depth: state bit lags the comparator by this many cycles
`define ACC_SYNC_STAGES      3

`endif

//--- logic/acc_pkg.sv
/*
 * Types shared by the comparator control modules.
 * Assumes the register header is included alongside where offsets are needed.
 */
`default_nettype none

package acc_pkg;
   // Edge choice for the interrupt flag
   typedef enum logic [1:0] {
      ACC_EDGE_ANY      = 2'h0,
      ACC_EDGE_RESERVED = 2'h1,
      ACC_EDGE_FALL     = 2'h2,
      ACC_EDGE_RISE     = 2'h3
   } acc_edge_e;

   // Negative input choices
   typedef enum logic [1:0] {
      ACC_NEG_PIN0 = 2'h0,
      ACC_NEG_PIN1 = 2'h1,
      ACC_NEG_VREF = 2'h2,
      ACC_NEG_DAC  = 2'h3
   } acc_neg_e;

   typedef logic [7:0] acc_byte_t;
endpackage : acc_pkg

`default_nettype wire

//--- logic/acc_cfg_if.sv
/*
 * Configuration and status bundle between the register file and the
 * comparator datapath. Assumes both ends share one clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface acc_cfg_if;
   import acc_pkg::*;
   logic       enable;
   logic       invert;
   logic [1:0] pos_sel;
   acc_neg_e   neg_sel;
   acc_edge_e  edge_sel;
   logic       state;
   logic       edge_event;

   // Register file drives settings and reads results
   modport regs (output enable, output invert, output pos_sel, output neg_sel,
                 output edge_sel, input state, input edge_event);
   // Datapath consumes settings and reports results
   modport core (input enable, input invert, input pos_sel, input neg_sel,
                 input edge_sel, output state, output edge_event);
endinterface : acc_cfg_if

`default_nettype wire

//--- logic/acc_sync.sv
/*
 * Comparator output conditioning: inversion, synchroniser and edge detect.
 * Assumes the raw comparator output is asynchronous to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acc_regs.svh"

module acc_sync
   import acc_pkg::*;
#(
   parameter int STAGES = `ACC_SYNC_STAGES
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic cmp_raw,
   acc_cfg_if.core   cfg
);
   // Refuse a chain too short for two raw stages plus the state stage
   if (STAGES < 3) begin : g_bad_stages
      $error("acc_sync needs at least three stages");
   end

   logic [STAGES-2:0] raw_reg;
   logic [STAGES-2:0] raw_next;
   logic              state_reg;
   logic              state_next;
   logic              prev_reg;
   logic              prev_next;
   logic              cond;
   logic              evt;

   // Gate only after two raw flops, so no glitch of the pin reaches logic
   // inversion for every consumer
   assign cond = cfg.enable & (raw_reg[STAGES-2] ^ cfg.invert);

   always_comb begin
      raw_next   = {raw_reg[STAGES-3:0], cmp_raw};
      state_next = cond;
      prev_next  = state_reg;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         raw_reg   <= '0;
         state_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         raw_reg   <= raw_next;
         state_reg <= state_next;
         prev_reg  <= prev_next;
      end
   end

   // Edge choice; reserved code raises nothing
   always_comb begin
      case (cfg.edge_sel)
         ACC_EDGE_ANY:  evt = state_reg ^ prev_reg;
         ACC_EDGE_FALL: evt = prev_reg & ~state_reg;
         ACC_EDGE_RISE: evt = ~prev_reg & state_reg;
         default:       evt = 1'b0;
      endcase
   end

   assign cfg.state      = state_reg;
   assign cfg.edge_event = evt;
endmodule : acc_sync

`default_nettype wire

//--- logic/acc_top.sv
/*
 * Analog comparator control: registers, input routing, state and interrupt.
 * Assumes a plain register port with read data one cycle after the strobe
 * and an asynchronous comparator output arriving on cmp_raw.
 */
// What this block does
// - Inversion bit flips comparator output for all consumers and status.
// - Positive select bits 4:3 route positive pins zero to three.
// - Negative select bits 1:0 pick pin zero, pin one, reference, DAC.
// - DAC choice always uses the DAC with this comparator's own index.
// - Interrupt enable bit 0 at offset 0x06, read-write, resets zero.
// - Status bit 4 shows comparator output after three-cycle synchroniser.
// - Interrupt flag bit 0 at offset 0x07, cleared by writing one.
// - Edge select picks both, falling or rising edges; code one reserved.
// - Interrupt request high while flag set and enable set.
// - Comparator operates and drives output only while enable bit is one.
`timescale 1ns/1ns
`default_nettype none
`include "acc_regs.svh"

module acc_top
   import acc_pkg::*;
#(
   parameter int INSTANCE = 0
) (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output var  logic [7:0] reg_rdata,
   input  wire logic       cmp_raw,
   output var  logic       cmp_enable,
   output var  logic [3:0] positive_pin_sel,
   output var  logic [3:0] negative_src_sel,
   output var  logic [1:0] dac_index,
   output var  logic       cmp_out,
   output var  logic       irq
);
   // Refuse an index that the two-bit DAC selector cannot name
   if (INSTANCE < 0 || INSTANCE > 3) begin : g_bad_instance
      $error("acc_top INSTANCE out of range");
   end

   // Typed copies of the header constants
   localparam acc_byte_t  CTRL_RST  = `ACC_CTRL_RST;
   localparam acc_byte_t  SEL_RST   = `ACC_SEL_RST;
   localparam acc_byte_t  IEN_RST   = `ACC_IRQ_EN_RST;
   localparam acc_byte_t  STAT_RST  = `ACC_STATUS_RST;
   localparam acc_byte_t  CTRL_MASK = `ACC_CTRL_MASK;
   localparam acc_byte_t  SEL_MASK  = `ACC_SEL_MASK;
   localparam logic [1:0] DAC_INDEX = 2'(INSTANCE);

   // Settings and results shared with the datapath
   acc_cfg_if cfg ();

   // Synchroniser, inversion, enable gate and edge detect
   acc_sync #(
      .STAGES (`ACC_SYNC_STAGES)
   ) u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .cmp_raw (cmp_raw),
      .cfg     (cfg)
   );

   // One-hot decode of a two-bit selection
   function automatic logic [3:0] acc_onehot(input logic [1:0] code);
      acc_onehot = 4'h1 << code;
   endfunction : acc_onehot

   // Strobe aimed at one register offset
   function automatic logic acc_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input acc_byte_t  ofs);
      acc_hit = strobe && (addr == ofs);
   endfunction : acc_hit

   // Control register: enable and edge choice
   acc_byte_t  ctrl_reg;
   acc_byte_t  ctrl_next;
   // Input select register: invert, positive and negative fields
   acc_byte_t  sel_reg;
   acc_byte_t  sel_next;
   // Interrupt enable bit
   logic       irq_en_reg;
   logic       irq_en_next;
   // Sticky interrupt flag
   logic       flag_reg;
   logic       flag_next;
   // Read data, zero outside the answer cycle
   acc_byte_t  rdata_reg;
   acc_byte_t  rdata_next;
   // Registered outputs
   logic       irq_reg;
   logic       irq_next;
   logic [3:0] pos_reg;
   logic [3:0] pos_next;
   logic [3:0] neg_reg;
   logic [3:0] neg_next;
   logic [1:0] dac_reg;
   logic [1:0] dac_next;
   logic       en_reg;
   logic       en_next;
   logic       out_reg;
   logic       out_next;
   // Decoded strobes
   logic       wr_ctrl;
   logic       wr_sel;
   logic       wr_ien;
   logic       wr_stat;
   logic       rd_ctrl;
   logic       rd_sel;
   logic       rd_ien;
   logic       rd_stat;
   logic       clr_req;

   // Write decode; unmapped offsets match nothing, so such writes vanish
   assign wr_ctrl = acc_hit(reg_write, reg_addr, `ACC_CTRL_OFS);
   assign wr_sel  = acc_hit(reg_write, reg_addr, `ACC_INPUT_SEL_OFS);
   assign wr_ien  = acc_hit(reg_write, reg_addr, `ACC_IRQ_ENABLE_OFS);
   assign wr_stat = acc_hit(reg_write, reg_addr, `ACC_STATE_FLAG_OFS);
   // Read decode; unmapped offsets leave the answer at zero
   assign rd_ctrl = acc_hit(reg_read, reg_addr, `ACC_CTRL_OFS);
   assign rd_sel  = acc_hit(reg_read, reg_addr, `ACC_INPUT_SEL_OFS);
   assign rd_ien  = acc_hit(reg_read, reg_addr, `ACC_IRQ_ENABLE_OFS);
   assign rd_stat = acc_hit(reg_read, reg_addr, `ACC_STATE_FLAG_OFS);
   assign clr_req = wr_stat && reg_wdata[`ACC_IRQ_BIT];

   // Settings towards the datapath
   // enable gates operation
   assign cfg.enable   = ctrl_reg[`ACC_CTRL_ENABLE_BIT];
   assign cfg.invert   = sel_reg[`ACC_SEL_INVERT_BIT];
   assign cfg.pos_sel  = sel_reg[`ACC_SEL_POS_MSB:`ACC_SEL_POS_LSB];
   assign cfg.neg_sel  = acc_neg_e'(sel_reg[`ACC_SEL_NEG_MSB:`ACC_SEL_NEG_LSB]);
   assign cfg.edge_sel = acc_edge_e'(ctrl_reg[`ACC_CTRL_EDGE_MSB:`ACC_CTRL_EDGE_LSB]);

   // Control register; bits with no function are masked so they read zero
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = reg_wdata & CTRL_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctrl_reg <= CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Input select register; spare bits masked on write
   always_comb begin
      sel_next = sel_reg;
      if (wr_sel) begin
         sel_next = reg_wdata & SEL_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sel_reg <= SEL_RST;
      end else begin
         sel_reg <= sel_next;
      end
   end

   // Interrupt enable; only bit 0 is stored
   // enable bit storage
   always_comb begin
      irq_en_next = irq_en_reg;
      if (wr_ien) begin
         irq_en_next = reg_wdata[`ACC_IRQ_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq_en_reg <= IEN_RST[`ACC_IRQ_BIT];
      end else begin
         irq_en_reg <= irq_en_next;
      end
   end

   // Sticky flag; the set is applied last so it wins over a clear in
   // the same cycle, and software never loses an edge it did not see
   always_comb begin
      flag_next = flag_reg;
      if (clr_req) begin
         flag_next = 1'b0;
      end
      if (cfg.edge_event) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         flag_reg <= STAT_RST[`ACC_IRQ_BIT];
      end else begin
         flag_reg <= flag_next;
      end
   end

   // Read answer, registered; stands one cycle after the strobe, else zero
   // Zero between reads keeps stale data off the shared read bus
   always_comb begin
      rdata_next = 8'h00;
      if (rd_ctrl) begin
         rdata_next = ctrl_reg;
      end
      if (rd_sel) begin
         rdata_next = sel_reg;
      end
      if (rd_ien) begin
         rdata_next = {7'h00, irq_en_reg};
      end
      if (rd_stat) begin
         rdata_next = {3'h0, cfg.state, 3'h0, flag_reg};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // request tracks flag and enable
   // Built from next values so the request moves on the same edge as the flag
   always_comb begin
      irq_next = flag_next & irq_en_next;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // Routing towards the analog side, all registered so that the
   // switches see one clean change per register write
   always_comb begin
      pos_next = acc_onehot(cfg.pos_sel);
      // negative source one-hot: pin0, pin1, reference, DAC
      neg_next = acc_onehot(cfg.neg_sel);
      dac_next = DAC_INDEX;
      en_next  = cfg.enable;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pos_reg <= 4'h1;
         neg_reg <= 4'h1;
         dac_reg <= DAC_INDEX;
         en_reg  <= 1'b0;
      end else begin
         pos_reg <= pos_next;
         neg_reg <= neg_next;
         dac_reg <= dac_next;
         en_reg  <= en_next;
      end
   end

   // Conditioned output for consumers; one stage behind the state bit,
   // a cycle of latency traded for a clean flip-flop output
   always_comb begin
      out_next = cfg.state;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         out_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
      end
   end

   // Top outputs, each straight from its flip-flop
   assign reg_rdata        = rdata_reg;
   assign irq              = irq_reg;
   assign positive_pin_sel = pos_reg;
   assign negative_src_sel = neg_reg;
   assign dac_index        = dac_reg;
   assign cmp_enable       = en_reg;
   assign cmp_out          = out_reg;
endmodule : acc_top

`default_nettype wire

//--- tb/acc_top_chk.sv
/* Concurrent checks on the comparator control block's ports.
   Assumes binding onto acc_top, one clock, synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module acc_top_chk #(
   parameter int INSTANCE = 0
) (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       cmp_enable,
   input wire logic [3:0] positive_pin_sel,
   input wire logic [3:0] negative_src_sel,
   input wire logic [1:0] dac_index,
   input wire logic       cmp_out,
   input wire logic       irq
);
   logic [7:0] sel_q;
   // Shadow of the last select write, to predict the one-hot outputs
   always_ff @(posedge ref_clk) begin
      if (reg_write && reg_addr == 8'h02) begin
         sel_q <= reg_wdata;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Select write followed by a quiet cycle, so the shadow is settled
   sequence s_sel_wr;
      reg_write && reg_addr == 8'h02 ##1 !(reg_write && reg_addr == 8'h02);
   endsequence
   property p_pos_sel;
      s_sel_wr |-> ##1 positive_pin_sel == 4'h1 << sel_q[4:3];
   endproperty
   property p_neg_sel;
      s_sel_wr |-> ##1 negative_src_sel == 4'h1 << sel_q[1:0];
   endproperty
   property p_dac_idx;
      dac_index == INSTANCE[1:0];
   endproperty
   property p_rd_idle;
      !$past(reg_read) |-> reg_rdata == 8'h00;
   endproperty
   property p_sta_rsv;
      reg_read && reg_addr == 8'h07 |=> (reg_rdata & 8'hEE) == 8'h00;
   endproperty
   // Long idle enable must leave the output low
   property p_off;
      !cmp_enable [*6] |-> !cmp_out;
   endproperty
   // Request only drops after a clear or a disable write
   property p_irq_fall;
      $fell(irq) |-> $past(reg_write) && $past(reg_addr) inside {8'h06, 8'h07};
   endproperty
   property p_en_clear;
      reg_write && reg_addr == 8'h06 && !reg_wdata[0] |-> ##[1:2] !irq;
   endproperty
   property p_w0_keep;
      irq && reg_write && reg_addr == 8'h07 && !reg_wdata[0] |=> irq;
   endproperty
   a_pos_sel: assert property (p_pos_sel) else $error("positive select wrong");
   a_neg_sel: assert property (p_neg_sel) else $error("negative select wrong");
   a_dac_idx: assert property (p_dac_idx) else $error("dac index wrong");
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_sta_rsv: assert property (p_sta_rsv) else $error("status spare bits set");
   a_off: assert property (p_off) else $error("output while disabled");
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell uncaused");
   a_en_clear: assert property (p_en_clear) else $error("irq kept when off");
   a_w0_keep: assert property (p_w0_keep) else $error("zero write cleared");
endmodule : acc_top_chk
bind acc_top acc_top_chk #(.INSTANCE(INSTANCE)) u_acc_top_chk (
   .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .cmp_enable(cmp_enable), .positive_pin_sel(positive_pin_sel),
   .negative_src_sel(negative_src_sel), .dac_index(dac_index), .cmp_out(cmp_out),
   .irq(irq));
`default_nettype wire

//--- tb/acc_top_tb.sv
/* Self-checking bench for acc_top: register, select, edge and irq tests.
   Assumes the checker file is compiled alongside and binds itself. */
`timescale 1ns/1ns
`default_nettype none
module acc_top_tb;
   logic       ref_clk   = 1'b0;
   logic       resetn    = 1'b0;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read  = 1'b0;
   logic       cmp_raw   = 1'b0;
   logic [7:0] reg_rdata;
   logic       cmp_enable, cmp_out, irq;
   logic [3:0] positive_pin_sel, negative_src_sel;
   logic [1:0] dac_index;
   int         n_mismatch  = 0;
   int         comparisons = 0;
   always #4 ref_clk = ~ref_clk;
   // Nonzero instance index, so a hardwired zero shows up
   acc_top #(.INSTANCE(2)) u_acc_top (.ref_clk(ref_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
      .cmp_enable(cmp_enable), .positive_pin_sel(positive_pin_sel),
      .negative_src_sel(negative_src_sel), .dac_index(dac_index),
      .cmp_out(cmp_out), .irq(irq));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask : wr
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk($sformatf("reg_%h", a), e, reg_rdata);
   endtask : rd
   // Long enough for the synchroniser chain and the output stage
   task automatic w8;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask : w8
   task automatic results;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(8'h00, 8'h00);
      wr(8'h01, 8'hFF);
      rd(8'h01, 8'h00);
      rd(8'h06, 8'h00);
      rd(8'h07, 8'h00);
      chk("dac_index", 8'h02, {6'h00, dac_index});
      wr(8'h02, 8'hFF);
      rd(8'h02, 8'h9B);
      for (int i = 0; i < 4; i++) begin
         wr(8'h02, 8'(i * 9));
         w8;
         chk("positive_pin_sel", 8'h01 << i, {4'h0, positive_pin_sel});
         chk("negative_src_sel", 8'h01 << i, {4'h0, negative_src_sel});
      end
      wr(8'h06, 8'h01);
      wr(8'h02, 8'h00);
      // Every edge mode, reserved one included, against both edges
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, 8'(m * 16 + 1));
         w8;
         wr(8'h07, 8'h01);
         @(posedge ref_clk) cmp_raw <= 1'b1;
         w8;
         wr(8'h07, 8'h00);
         rd(8'h07, 8'(16 + (m == 0 || m == 3)));
         chk("irq", 8'(m == 0 || m == 3), {7'h00, irq});
         chk("cmp_out", 8'h01, {7'h00, cmp_out});
         wr(8'h07, 8'h01);
         @(posedge ref_clk) cmp_raw <= 1'b0;
         w8;
         rd(8'h07, 8'(m == 0 || m == 2));
      end
      wr(8'h02, 8'h80);
      w8;
      chk("cmp_out", 8'h01, {7'h00, cmp_out});
      rd(8'h07, 8'h11);
      wr(8'h06, 8'h00);
      w8;
      chk("irq", 8'h00, {7'h00, irq});
      wr(8'h00, 8'h00);
      w8;
      chk("cmp_enable", 8'h00, {7'h00, cmp_enable});
      chk("cmp_out", 8'h00, {7'h00, cmp_out});
      rd(8'h07, 8'h01);
      results;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge ref_clk);
      n_mismatch++;
      results;
   end
endmodule : acc_top_tb
`default_nettype wire
